// [rtl/sapc_host.sv]
// host end: issues conversions, catches results through a two-entry buffer
`timescale 1ns/10ps
module sapc_host
	import sapc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	sapc_if.host pins,
	input wire logic start, // request one conversion
	output logic start_ready, // high when a start will be taken
	output sapc_pkg::sapc_word_t res_data,
	output logic res_valid,
	input wire logic res_ready
);
	import sapc_pkg::*;

	typedef enum logic [2:0] {SAPH_IDLE, SAPH_SETUP, SAPH_PULSE, SAPH_WAIT, SAPH_GAP} saph_st_t;

	saph_st_t st_reg;
	logic [CNT_W-1:0] cnt_reg; // phase timer
	logic [CNT_W-1:0] gap_reg; // spacing since last request
	logic sel_b_reg;
	logic rc_reg;
	logic busy_m_reg; // first synchroniser stage
	logic busy_s_reg; // second stage
	logic busy_d_reg; // edge detect history
	logic rise;
	sapc_word_t buf_reg [2]; // two-entry buffer, index addressed
	logic [1:0] cnt_buf_reg;
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic ready_reg;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////
	// busy synchroniser; only the second stage feeds logic
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			busy_m_reg <= 1'b1;
			busy_s_reg <= 1'b1;
			busy_d_reg <= 1'b1;
		end else if (clk_en) begin
			busy_m_reg <= pins.busy_b; // RL14
			busy_s_reg <= busy_m_reg;
			busy_d_reg <= busy_s_reg;
		end
	end
	assign rise = busy_s_reg & ~busy_d_reg;

	////////////////////////////////////////////////////////////////
	// sequencer: rc low first, then select falls to start
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= SAPH_IDLE;
			cnt_reg <= CNT_ZERO;
			sel_b_reg <= 1'b1;
			rc_reg <= 1'b1;
		end else if (clk_en) begin
			unique case (st_reg)
				SAPH_IDLE: begin
					// gap held off until buffer has room, so a result is never dropped
					if (start && ready_reg) begin
						st_reg <= SAPH_SETUP;
						rc_reg <= 1'b0;
						cnt_reg <= CNT_W'(SETUP_CYC - 1);
					end
				end
				SAPH_SETUP: begin
					if (cnt_reg == CNT_ZERO) begin // RL8
						st_reg <= SAPH_PULSE;
						sel_b_reg <= 1'b0;
						cnt_reg <= CNT_W'(CONV_PULSE_CYC + 1); // margin over the device qualifier
					end else begin
						cnt_reg <= cnt_reg - CNT_ONE;
					end
				end
				SAPH_PULSE: begin
					if (cnt_reg == CNT_ZERO) begin // RL1
						st_reg <= SAPH_WAIT;
						rc_reg <= 1'b1; // select stays low: read on completion
					end else begin
						cnt_reg <= cnt_reg - CNT_ONE;
					end
				end
				SAPH_WAIT: begin
					// bus left quiet while busy; capture on the rising edge
					if (rise) begin // RL11 RL12
						st_reg <= SAPH_GAP;
					end
				end
				SAPH_GAP: begin
					if (gap_reg == CNT_ZERO) begin // RL4
						st_reg <= SAPH_IDLE;
						sel_b_reg <= 1'b1;
					end
				end
				// unused state codes fall back to idle
				default: begin
					st_reg <= SAPH_IDLE;
				end
			endcase
		end
	end

	// spacing counter from the start of each request
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			gap_reg <= CNT_ZERO;
		end else if (clk_en) begin
			if (st_reg == SAPH_IDLE && start && ready_reg) begin
				gap_reg <= CNT_W'(BETWEEN_CYC - 1); // RL4
			end else if (gap_reg != CNT_ZERO) begin
				gap_reg <= gap_reg - CNT_ONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// result buffer
	assign push = clk_en & (st_reg == SAPH_WAIT) & rise;
	assign pop = clk_en & (cnt_buf_reg != 2'h0) & res_ready;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			buf_reg[0] <= CODE_MID;
			buf_reg[1] <= CODE_MID;
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_buf_reg <= 2'h0;
		end else begin
			if (push) begin
				buf_reg[wr_ptr_reg] <= pins.result_bus;
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			cnt_buf_reg <= cnt_buf_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// room for one more result, counting any in flight
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ready_reg <= 1'b1;
		end else begin
			ready_reg <= (cnt_buf_reg + {1'b0, push} - {1'b0, pop}) < 2'h2;
		end
	end

	assign pins.sel_b = sel_b_reg;
	assign pins.rc = rc_reg;
	assign res_data = buf_reg[rd_ptr_reg];
	assign res_valid = cnt_buf_reg != 2'h0;
	assign start_ready = ready_reg & (st_reg == SAPH_IDLE);
endmodule : sapc_host

// [shared/sapc_pkg.sv]
// package: constants and types shared by both ends of the converter control link
package sapc_pkg;
	localparam int CLK_MHZ = 200;
	localparam int RES_W = 12;
	localparam logic [RES_W-1:0] CODE_POS_FS = 12'h7FF;
	localparam logic [RES_W-1:0] CODE_MID = 12'h000;
	localparam logic [RES_W-1:0] CODE_NEG_FS = 12'h800;
	localparam int T_CONV_PULSE_NS = 40;
	localparam int T_SETUP_NS = 10;
	localparam int T_BUSY_DLY_NS = 70;
	localparam int T_BUSY_LOW_NS = 960;
	localparam int T_VALID_TO_BUSY_NS = 65;
	localparam int T_BETWEEN_NS = 1250;
	localparam int CONV_PULSE_CYC = (T_CONV_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int BUSY_DLY_CYC = (T_BUSY_DLY_NS * CLK_MHZ) / 1000;
	localparam int BUSY_LOW_CYC = (T_BUSY_LOW_NS * CLK_MHZ) / 1000;
	localparam int VALID_CYC = (T_VALID_TO_BUSY_NS * CLK_MHZ) / 1000;
	localparam int BETWEEN_CYC = (T_BETWEEN_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 9;
	localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
	typedef logic [RES_W-1:0] sapc_word_t;
endpackage : sapc_pkg

// [shared/sapc_if.sv]
// interface: the parallel pins between host and converter
`timescale 1ns/10ps
interface sapc_if;
	import sapc_pkg::*;
	logic sel_b; // select, active low
	logic rc; // high read, low convert
	logic busy_b; // busy, active low
	sapc_word_t result_bus_o; // device drive value
	logic result_bus_oe_b; // low while the device drives
	sapc_word_t result_bus; // resolved bus level seen by host
	assign result_bus = result_bus_oe_b ? 12'hFFF : result_bus_o;
	modport dev (input sel_b, input rc, output busy_b, output result_bus_o, output result_bus_oe_b);
	modport host (output sel_b, output rc, input busy_b, input result_bus);
endinterface : sapc_if

// [rtl/sapc_dev.sv]
// device end: conversion sequencer, busy and result bus drive
`timescale 1ns/10ps
//
// Contract
// [RL1] both low 40ns holds and converts
// [RL2] busy low until result loaded
// [RL3] requests ignored while busy low
// [RL4] host spaces requests 1.25us apart
// [RL5] result is one parallel 12-bit word
// [RL6] result coded in two's complement
// [RL7] request is OR of low levels; the decode here ANDs them, both must be low
// [RL8] host sets other input 10ns early
// [RL9] bus driven only read, selected, idle
// [RL10] select tied low works read/convert
// [RL11] busy rises after result is loaded
// [RL12] host keeps bus quiet converting
// [RL13] internal time base, constant durations
// [RL14] host synchronises busy first
//
// one conversion, in clock cycles after the accepting edge:
//   +0    sample frozen, sequencer leaves idle, bus stays released
//   +14   busy falls
//   +193  result register loaded, done pulse
//   +206  busy rises, the new word already in the register
//   +207  bus driven again when read/convert is high and select low
// a request is taken on the eighth edge at which it stands
// the counts come from nanosecond figures at the system clock rate;
// a slower clock rounds the busy delay and the valid lead down, which
// shortens them: check the package before changing the clock
//
// limitation: pins are taken as synchronous; a host on another clock
// must register select and read/convert before they reach this block
//
module sapc_dev
	import sapc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	sapc_if.dev pins,
	input wire sapc_pkg::sapc_word_t sample_in, // two's complement code from the quantiser
	output logic conv_done // pulse when a result is loaded
);
	import sapc_pkg::*;

	typedef enum logic [1:0] {SAPC_IDLE, SAPC_DLY, SAPC_CONV, SAPC_LOAD} sapc_st_t;

	// every register here is frozen while clk_en is low, timers included,
	// so phase lengths stretch by the frozen cycles
	sapc_st_t st_reg; // sequencer state
	logic [CNT_W-1:0] cnt_reg; // shared timer
	logic [CNT_W-1:0] req_cnt_reg; // cycles the request has stood
	logic req_arm_reg; // request must release before it can fire again
	sapc_word_t hold_reg; // held sample
	sapc_word_t result_reg; // output register
	logic busy_b_reg;
	logic oe_b_reg;
	logic done_reg;
	logic req;
	logic accept; // request taken this cycle

	////////////////////////////////////////////////////////////////
	// request decode: low levels AND'd, no edge ordering needed
	// a host that needs one input to initiate must lower the other first
	assign req = ~pins.sel_b & ~pins.rc; // RL7 RL10

	// one term for the accepting edge keeps the sequencer, the arm flag and the
	// sample hold agreeing on the very same cycle
	assign accept = req & req_arm_reg & (st_reg == SAPC_IDLE)
		& (req_cnt_reg == CNT_W'(CONV_PULSE_CYC - 1)); // RL1 RL3

	// qualify the request width; a glitch shorter than the pulse minimum is dropped
	// the counter saturates at the pulse minimum so a long hold cannot wrap
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			req_cnt_reg <= CNT_ZERO;
		end else if (clk_en) begin
			if (!req) begin
				req_cnt_reg <= CNT_ZERO;
			end else if (req_cnt_reg < CNT_W'(CONV_PULSE_CYC)) begin
				req_cnt_reg <= req_cnt_reg + CNT_ONE;
			end
		end
	end

	// a held-low request starts only one conversion
	// the width counter, held at 8 past the compare value 7, also keeps a host
	// that holds both inputs low from restarting the converter at idle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			req_arm_reg <= 1'b1;
		end else if (clk_en) begin
			if (!req) begin
				req_arm_reg <= 1'b1;
			end else if (accept) begin
				req_arm_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// sequencer: hold, busy delay, busy low, load
	// each phase loads the timer with its length minus one and leaves at zero
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= SAPC_IDLE;
			cnt_reg <= CNT_ZERO;
		end else if (clk_en) begin
			unique case (st_reg)
				SAPC_IDLE: begin
					// only an idle sequencer sees requests
					if (accept) begin // RL1 RL3
						st_reg <= SAPC_DLY;
						cnt_reg <= CNT_W'(BUSY_DLY_CYC - 1);
					end
				end
				SAPC_DLY: begin
					// busy delay: bus already released, busy still high
					if (cnt_reg == CNT_ZERO) begin
						st_reg <= SAPC_CONV;
						cnt_reg <= CNT_W'(BUSY_LOW_CYC - VALID_CYC - 1); // RL13
					end else begin
						cnt_reg <= cnt_reg - CNT_ONE;
					end
				end
				SAPC_CONV: begin
					// converting: busy low, sample held
					if (cnt_reg == CNT_ZERO) begin
						st_reg <= SAPC_LOAD;
						cnt_reg <= CNT_W'(VALID_CYC - 1);
					end else begin
						cnt_reg <= cnt_reg - CNT_ONE;
					end
				end
				SAPC_LOAD: begin
					// result already loaded; busy rises when this runs out
					if (cnt_reg == CNT_ZERO) begin // RL11
						st_reg <= SAPC_IDLE;
					end else begin
						cnt_reg <= cnt_reg - CNT_ONE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// sample hold: input frozen the cycle the conversion begins
	// later changes on the quantiser input cannot disturb a running conversion
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hold_reg <= CODE_MID;
		end else if (clk_en && accept) begin
			hold_reg <= sample_in; // RL1
		end
	end

	// output register loads at the end of the conversion phase
	// it only changes while busy is low, so a host latching on the rising
	// busy edge always sees a settled word
	// reset leaves midscale so a read before any conversion returns zero
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			result_reg <= CODE_MID;
			done_reg <= 1'b0;
		end else if (clk_en) begin
			done_reg <= 1'b0;
			if (st_reg == SAPC_CONV && cnt_reg == CNT_ZERO) begin
				result_reg <= hold_reg; // RL5 RL6
				done_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// busy: low from the delay's end through the load phase
	// a register of its own rather than a state decode, so the pin never
	// glitches between phases
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			busy_b_reg <= 1'b1;
		end else if (clk_en) begin
			if (st_reg == SAPC_DLY && cnt_reg == CNT_ZERO) begin
				busy_b_reg <= 1'b0; // RL2
			end else if (st_reg == SAPC_LOAD && cnt_reg == CNT_ZERO) begin
				busy_b_reg <= 1'b1; // RL2 RL11
			end
		end
	end

	// bus drive: read, selected and idle; the busy delay is not idle
	// so the bus lets go as soon as a conversion is accepted
	// the enable lags the pins by one cycle; a read strobe shorter than a
	// cycle may never see the word
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			oe_b_reg <= 1'b1;
		end else if (clk_en) begin
			oe_b_reg <= ~(pins.rc & ~pins.sel_b & st_reg == SAPC_IDLE); // RL9 RL10
		end
	end

	////////////////////////////////////////////////////////////////
	// pin drive: all straight from registers; the released level is the interface's
	assign pins.busy_b = busy_b_reg;
	assign pins.result_bus_o = result_reg; // RL5
	assign pins.result_bus_oe_b = oe_b_reg;
	assign conv_done = done_reg;
endmodule : sapc_dev

// [tb/sapc_link_properties.sv]
// checker: timing relations on the converter link pins
`timescale 1ns/10ps
module sapc_link_properties
	import sapc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic sel_b,
	input wire logic rc,
	input wire logic busy_b,
	input wire sapc_pkg::sapc_word_t result_bus_o,
	input wire logic result_bus_oe_b
);
	import sapc_pkg::*;
	logic [CNT_W-1:0] low_cnt_reg; // cycles busy has been low
	logic req; // combined convert request
	assign req = !sel_b && !rc;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// count busy low so the pulse length is checked exactly
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) low_cnt_reg <= CNT_ZERO;
		else if (!busy_b) low_cnt_reg <= low_cnt_reg + CNT_ONE;
		else low_cnt_reg <= CNT_ZERO;
	end
	busy_start_a: assert property ($fell(busy_b) |-> $past(req, 16))
		else $error("busy fell without a held request");
	busy_len_a: assert property ($rose(busy_b) |-> low_cnt_reg == CNT_W'(BUSY_LOW_CYC))
		else $error("busy low length wrong");
	busy_hold_a: assert property (!busy_b && low_cnt_reg < CNT_W'(BUSY_LOW_CYC - 1) |=> !busy_b)
		else $error("conversion cut short");
	hiz_busy_a: assert property (!busy_b |-> result_bus_oe_b)
		else $error("bus driven while converting");
	hiz_idle_a: assert property (sel_b || !rc |=> result_bus_oe_b)
		else $error("bus driven without read select");
	drive_done_a: assert property ($rose(busy_b) && !sel_b && rc |-> ##[0:1] !result_bus_oe_b)
		else $error("bus not driven at end of conversion");
	word_stable_a: assert property (!result_bus_oe_b && $past(!result_bus_oe_b) |-> $stable(result_bus_o))
		else $error("driven word changed");
	load_in_busy_a: assert property ($changed(result_bus_o) |-> !busy_b[*8])
		else $error("result loaded outside busy");
	cover property ($fell(busy_b));
	cover property ($rose(busy_b) && !sel_b && rc);
	cover property (sel_b && busy_b && result_bus_oe_b);
endmodule : sapc_link_properties

// [tb/sar_adc_parallel_control_test.sv]
// testbench: host and device ends joined over the link
`timescale 1ns/10ps
module sar_adc_parallel_control_test;
	import sapc_pkg::*;
	logic clk_sys, rst_b, start, start_ready, res_valid, res_ready, conv_done;
	sapc_word_t sample_in, res_data;
	sapc_word_t done_seen; // done pulses counted from reset
	int fail_count, cmp_count;
	sapc_if link();
	sapc_dev u_sapc_dev (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1), .pins(link),
		.sample_in(sample_in), .conv_done(conv_done));
	sapc_host u_sapc_host (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1), .pins(link),
		.start(start), .start_ready(start_ready), .res_data(res_data), .res_valid(res_valid),
		.res_ready(res_ready));
	sapc_link_properties u_props (.clk_sys(clk_sys), .rst_b(rst_b), .sel_b(link.sel_b),
		.rc(link.rc), .busy_b(link.busy_b), .result_bus_o(link.result_bus_o),
		.result_bus_oe_b(link.result_bus_oe_b));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// the done pulse stands one cycle, so every edge is looked at
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) done_seen <= 12'h000;
		else if (conv_done === 1'b1) done_seen <= done_seen + 12'h001;
	end
	////////////////////////////////////////
	task automatic chk(input string what, input sapc_word_t exp, input sapc_word_t got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	// bounded wait for a busy level
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (link.busy_b !== lvl && n < 400) begin
			step(1);
			n++;
		end
		chk("busy level", {11'h000, lvl}, {11'h000, link.busy_b});
	endtask : wait_busy
	task automatic do_conv(input sapc_word_t code);
		int n;
		n = 0;
		while (start_ready !== 1'b1 && n < 600) begin
			step(1);
			n++;
		end
		sample_in = code;
		start = 1'b1;
		step(1);
		start = 1'b0;
	endtask : do_conv
	// pop one word from the buffer and compare
	task automatic get_res(input sapc_word_t code);
		int n;
		n = 0;
		res_ready = 1'b1;
		while (res_valid !== 1'b1 && n < 600) begin
			step(1);
			n++;
		end
		chk("result", code, res_data);
		step(1);
		res_ready = 1'b0;
		step(1);
	endtask : get_res
	////////////////////////////////////////
	task automatic t_codes;
		sapc_word_t codes[4];
		codes = '{CODE_POS_FS, CODE_MID, 12'hFFF, CODE_NEG_FS};
		chk("idle bus", 12'hFFF, link.result_bus);
		foreach (codes[i]) begin
			do_conv(codes[i]);
			wait_busy(1'b0);
			wait_busy(1'b1);
			step(1);
			chk("bus at done", codes[i], link.result_bus);
			get_res(codes[i]);
		end
		$display("test codes done");
	endtask : t_codes
	task automatic t_refuse;
		do_conv(12'h5A3);
		wait_busy(1'b0);
		chk("ready while busy", 12'h000, {11'h000, start_ready});
		start = 1'b1;
		step(1);
		start = 1'b0;
		wait_busy(1'b1);
		get_res(12'h5A3);
		step(300);
		chk("no extra result", 12'h000, {11'h000, res_valid});
		$display("test refuse done");
	endtask : t_refuse
	task automatic t_stall;
		realtime t0;
		sample_in = 12'h3C1;
		start = 1'b1;
		wait_busy(1'b0);
		t0 = $realtime;
		sample_in = 12'hC3E;
		wait_busy(1'b1);
		wait_busy(1'b0);
		start = 1'b0;
		chk("spacing", 12'h001, {11'h000, ($realtime - t0) >= BETWEEN_CYC * 5.0});
		wait_busy(1'b1);
		step(260);
		chk("full refuses", 12'h000, {11'h000, start_ready});
		get_res(12'h3C1);
		get_res(12'hC3E);
		chk("drained", 12'h000, {11'h000, res_valid});
		chk("done pulses", 12'h007, done_seen);
		$display("test stall done");
	endtask : t_stall
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		fail_count = 0;
		cmp_count = 0;
		start = 1'b0;
		res_ready = 1'b0;
		sample_in = 12'h000;
		rst_b = 1'b0;
		step(10);
		rst_b = 1'b1;
		t_codes;
		t_refuse;
		t_stall;
		wrap_up;
	end
	// cut a hang short
	initial begin
		repeat (8000) @(posedge clk_sys);
		fail_count++;
		wrap_up;
	end
endmodule : sar_adc_parallel_control_test
